//--- verification/dds_frequency_synth_control_test.sv
`timescale 1ns/1ps
module dds_frequency_synth_control_test;
   reg sys_clk_i = 1'b0;
   reg srst_i = 1'b1;
   reg [3:0] a = 4'h0;
   reg [31:0] wd = 32'h0;
   reg wr = 1'b0, rd = 1'b0, lock = 1'b0, sb = 1'b0, mreq = 1'b0, treq = 1'b0, rx = 1'b0;
   wire md, tx, pump, osc, fska;
   wire [31:0] rdat;
   wire [23:0] ph, fw;
   wire [9:0] fb;
   wire [2:0] gn;
   integer errors = 0, samples_checked = 0, cyc = 0;
   reg [23:0] p;
   always #50 sys_clk_i = ~sys_clk_i;
   dfs_host u_host (.sys_clk_i(sys_clk_i), .mode_req_i(mreq), .tx_req_i(treq), .rx_i(rx),
      .mode_sel_o(md), .tx_data_o(tx));
   dfs_synth_ctrl u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(a),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .mode_sel_i(md),
      .tx_data_i(tx), .pll_locked_i(lock), .standby_i(sb), .phase_o(ph), .freq_word_o(fw),
      .fb_divide_o(fb), .acquisition_pump_output_o(pump), .acq_pump_gain_o(gn),
      .oscillator_enable_bit_o(osc), .fsk_active_o(fska));
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("wrong value %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task wt(input integer n);
      begin
         repeat (n) @(posedge sys_clk_i);
         #1;
      end
   endtask
   task wreg(input [3:0] ad, input [31:0] d);
      begin
         @(posedge sys_clk_i);
         a <= ad;
         wd <= d;
         wr <= 1'b1;
         @(posedge sys_clk_i);
         wr <= 1'b0;
      end
   endtask
   task rreg(input [3:0] ad, input [31:0] e);
      begin
         @(posedge sys_clk_i);
         a <= ad;
         rd <= 1'b1;
         @(posedge sys_clk_i);
         rd <= 1'b0;
         #1;
         chk("rdata", rdat, e);
      end
   endtask
   task summarize;
      begin
         $display("checked %0d mismatches %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task t_regs;
      begin
         chk("fb", fb, 32'h100);
         chk("fsk", fska, 32'h1);
         wreg(4'h0, 32'hffff_ffff);
         rreg(4'h0, 32'h003f_ffff);
         wreg(4'h4, 32'h0012_3456);
         rreg(4'h4, 32'h0012_3456);
         rreg(4'h1, 32'h0);
         $display("regs done");
      end
   endtask
   task t_fsk;
      begin
         wreg(4'h8, 32'h0000_0dff);
         wt(6);
         chk("fb", fb, 32'h200);
         chk("gain", gn, 32'h5);
         chk("osc", osc, 32'h0);
         chk("fw", fw, 32'h3f_ffff);
         @(posedge sys_clk_i) treq <= 1'b1;
         wt(6);
         p = ph;
         chk("fw", fw, 32'h40_03fb);
         wt(1);
         chk("phase", ph, {8'h00, p + 24'h40_03fb});
         @(posedge sys_clk_i) rx <= 1'b1;
         wt(6);
         chk("fw", fw, 32'h3f_ffff);
         wreg(4'h8, 32'hffff_ffff);
         rreg(4'h8, 32'h0001_ffff);
         wt(4);
         chk("fsk", fska, 32'h0);
         chk("osc", osc, 32'h1);
         @(posedge sys_clk_i) rx <= 1'b0;
         wt(6);
         chk("fw", fw, 32'h3f_ffff);
         @(posedge sys_clk_i) mreq <= 1'b1;
         wt(6);
         chk("fw", fw, 32'h12_3456);
         rreg(4'hc, 32'h0000_0001);
         $display("fsk done");
      end
   endtask
   task t_pins;
      begin
         @(posedge sys_clk_i) lock <= 1'b1;
         wt(5);
         chk("pump", pump, 32'h0);
         @(posedge sys_clk_i) lock <= 1'b0;
         sb <= 1'b1;
         wt(5);
         chk("pump", pump, 32'h1);
         @(posedge sys_clk_i) sb <= 1'b0;
         rreg(4'h0, 32'h003f_ffff);
         chk("fw", fw, 32'h12_3456);
         $display("pins done");
      end
   endtask
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         summarize;
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      wt(1);
      t_regs;
      t_fsk;
      t_pins;
      summarize;
   end
endmodule // dds_frequency_synth_control_test

//--- verification/dfs_host.sv
`timescale 1ns/1ps
module dfs_host (
   input wire sys_clk_i,
   input wire mode_req_i,
   input wire tx_req_i,
   input wire rx_i,
   output reg mode_sel_o = 1'b0,
   output reg tx_data_o = 1'b0
);
   always @(posedge sys_clk_i) begin
      mode_sel_o <= mode_req_i;
      // Held low in receive so the deviation never pulls the LO
      tx_data_o <= tx_req_i & ~rx_i;
   end
endmodule // dfs_host

//--- verification/dfs_synth_ctrl_assertions.sv
`timescale 1ns/1ps
module dfs_chk (
   input wire sys_clk_i, srst_i, reg_wr_i, reg_rd_i, pll_locked_i,
   input wire [31:0] reg_rdata_o,
   input wire [23:0] phase_o, freq_word_o,
   input wire [9:0] fb_divide_o,
   input wire [2:0] acq_pump_gain_o,
   input wire acquisition_pump_output_o, fsk_active_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   AST_PHASE: assert property (!$past(srst_i) |->
      phase_o == $past(phase_o) + $past(freq_word_o)) else $error("phase step");
   AST_DIV_SET: assert property (fb_divide_o == 10'h100 || fb_divide_o == 10'h200)
      else $error("divide value");
   AST_DIV_HOLD: assert property ($changed(fb_divide_o) |->
      $past(reg_wr_i | srst_i) || $past(reg_wr_i | srst_i, 2)) else $error("divide moved");
   AST_GAIN_HOLD: assert property ($changed(acq_pump_gain_o) |->
      $past(reg_wr_i | srst_i) || $past(reg_wr_i | srst_i, 2)) else $error("gain moved");
   AST_MODE_HOLD: assert property ($changed(fsk_active_o) |->
      $past(reg_wr_i | srst_i) || $past(reg_wr_i | srst_i, 2)) else $error("mode moved");
   AST_TOP_BITS: assert property (!fsk_active_o && !$past(fsk_active_o) &&
      !$past(fsk_active_o, 2) |-> freq_word_o[23:22] == 2'h0) else $error("top bits");
   AST_PUMP_OFF: assert property (pll_locked_i [*4] |-> !acquisition_pump_output_o)
      else $error("pump on in lock");
   AST_PUMP_ON: assert property (!pll_locked_i [*4] |-> acquisition_pump_output_o)
      else $error("pump off unlocked");
   AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data idle");
endmodule // dfs_chk
bind dfs_synth_ctrl dfs_chk u_chk (.*);

//--- verilog/dfs_defs.vh
// Overview of operation
// - A 24-bit phase accumulator updates once per reference clock cycle.
// - Each stored frequency setting is 22 bits and enters the 24-bit word with two zero MSBs.
// - The mode pin selects the mode0 or mode1 frequency setting as the frequency word.
// - Bit 16 of the mode1 control word at zero selects FSK and applies the 8-bit deviation.
// - With FSK, transmit data low leaves the setting unchanged; high adds four times deviation.
// - Frequency settings stay unchanged through standby.
// - The feedback divide ratio is 256 or 512, chosen by a mode1 control word bit.
// - The acquisition pump gain comes from a three-bit field of the mode1 control word.
// - The acquisition pump is enabled only while the loop is unlocked.
`ifndef DFS_DEFS_VH
`define DFS_DEFS_VH
// ----------------------------------------
// Register map (byte address, word index = address / 4)
// ----------------------------------------
`define DFS_ADDR_MODE0_FREQ 4'h0
`define DFS_ADDR_MODE1_FREQ 4'h4
`define DFS_ADDR_MODE1_CTRL 4'h8
`define DFS_ADDR_STATUS 4'hc
// ----------------------------------------
// Mode1 control word fields
// ----------------------------------------
`define DFS_DEV_LSB 0
`define DFS_DEV_MSB 7
`define DFS_GAIN_LSB 8
`define DFS_GAIN_MSB 10
`define DFS_DIV_BIT 11
`define DFS_OSC_EN_BIT 12
`define DFS_MM_BIT 16
`define DFS_CTRL_MASK 32'h0001_1fff
// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define DFS_FREQ_RST 22'h000000
`define DFS_CTRL_RST 17'h00000
`define DFS_ACC_W 24
`define DFS_FREQ_W 22
`define DFS_DIV_LO 10'h100
`define DFS_DIV_HI 10'h200
`endif

//--- verilog/dfs_phase_acc.v
`timescale 1ns/1ps
`include "dfs_defs.vh"
module dfs_phase_acc #(
   parameter W = 24
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Frequency word in, phase out
   input wire [W-1:0] freq_word_i,
   output wire [W-1:0] phase_o
);
   reg [W-1:0] phase_r;
   wire [W-1:0] phase_nxt;
   // Plain W-bit add drops the carry, giving natural wrap
   assign phase_nxt = phase_r + freq_word_i;
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         phase_r <= {W{1'b0}};
      end else begin
         phase_r <= phase_nxt;
      end
   end
   assign phase_o = phase_r;
endmodule // dfs_phase_acc

//--- verilog/dfs_sync2.v
`timescale 1ns/1ps
module dfs_sync2 (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Async level in, synced out
   input wire async_i,
   output wire sync_o
);
   reg meta_r;
   reg sync_r;
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end
   assign sync_o = sync_r;
endmodule // dfs_sync2

//--- verilog/dfs_synth_ctrl.v
`timescale 1ns/1ps
`include "dfs_defs.vh"
module dfs_synth_ctrl (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Register port
   input wire [3:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [31:0] reg_rdata_o,
   // Device pins
   input wire mode_sel_i,
   input wire tx_data_i,
   input wire pll_locked_i,
   input wire standby_i,
   // Synthesizer outputs
   output wire [23:0] phase_o,
   output wire [23:0] freq_word_o,
   output wire [9:0] fb_divide_o,
   output wire acquisition_pump_output_o,
   output wire [2:0] acq_pump_gain_o,
   output wire oscillator_enable_bit_o,
   output wire fsk_active_o
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire mode_s;
   wire tx_s;
   wire lock_s;
   dfs_sync2 u_sync_mode (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(mode_sel_i),
      .sync_o(mode_s)
   );
   dfs_sync2 u_sync_tx (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(tx_data_i),
      .sync_o(tx_s)
   );
   dfs_sync2 u_sync_lock (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(pll_locked_i),
      .sync_o(lock_s)
   );
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [21:0] mode0_freq_setting_r;
   reg [21:0] mode1_freq_setting_r;
   reg [16:0] ctrl_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;
   // Standby is not a write term: settings survive it untouched
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         mode0_freq_setting_r <= `DFS_FREQ_RST;
         mode1_freq_setting_r <= `DFS_FREQ_RST;
         ctrl_r <= `DFS_CTRL_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `DFS_ADDR_MODE0_FREQ: begin
               mode0_freq_setting_r <= reg_wdata_i[21:0];
            end
            `DFS_ADDR_MODE1_FREQ: begin
               mode1_freq_setting_r <= reg_wdata_i[21:0];
            end
            `DFS_ADDR_MODE1_CTRL: begin
               ctrl_r <= reg_wdata_i[16:0];
            end
            default: begin
            end
         endcase
      end
   end
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (reg_addr_i)
         `DFS_ADDR_MODE0_FREQ: rdata_nxt = {10'h000, mode0_freq_setting_r};
         `DFS_ADDR_MODE1_FREQ: rdata_nxt = {10'h000, mode1_freq_setting_r};
         `DFS_ADDR_MODE1_CTRL: rdata_nxt = {15'h0000, ctrl_r};
         `DFS_ADDR_STATUS: rdata_nxt = {28'h0000000, standby_i, fsk_active_o, lock_s, mode_s};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end
   // Read data stand only in the cycle after the strobe
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end
   assign reg_rdata_o = rdata_r;
   // ----------------------------------------
   // Frequency word
   // ----------------------------------------
   wire [21:0] sel_freq;
   wire [23:0] base_word;
   wire [7:0] dev;
   wire [23:0] dev_word;
   wire fsk_sel;
   reg [23:0] freq_word_r;
   reg [23:0] freq_word_nxt;
   assign sel_freq = mode_s ? mode1_freq_setting_r : mode0_freq_setting_r;
   assign base_word = {2'b00, sel_freq};
   assign fsk_sel = ~ctrl_r[`DFS_MM_BIT];
   assign dev = ctrl_r[`DFS_DEV_MSB:`DFS_DEV_LSB];
   assign dev_word = {14'h0000, dev, 2'b00};
   // Word is registered so the accumulator sees a clean, glitch-free step
   always @* begin
      freq_word_nxt = base_word;
      if (fsk_sel && tx_s) begin
         freq_word_nxt = base_word + dev_word;
      end
   end
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         freq_word_r <= 24'h000000;
      end else begin
         freq_word_r <= freq_word_nxt;
      end
   end
   assign freq_word_o = freq_word_r;
   assign fsk_active_o = fsk_sel;
   dfs_phase_acc #(
      .W(`DFS_ACC_W)
   ) u_acc (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .freq_word_i(freq_word_r),
      .phase_o(phase_o)
   );
   // ----------------------------------------
   // Loop controls
   // ----------------------------------------
   reg pump_en_r;
   reg [9:0] div_r;
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         pump_en_r <= 1'b0;
         div_r <= `DFS_DIV_LO;
      end else begin
         pump_en_r <= ~lock_s;
         div_r <= ctrl_r[`DFS_DIV_BIT] ? `DFS_DIV_HI : `DFS_DIV_LO;
      end
   end
   assign acquisition_pump_output_o = pump_en_r;
   assign fb_divide_o = div_r;
   assign acq_pump_gain_o = ctrl_r[`DFS_GAIN_MSB:`DFS_GAIN_LSB];
   // Set to 0 by software when an external oscillator drives the chip
   assign oscillator_enable_bit_o = ctrl_r[`DFS_OSC_EN_BIT];
endmodule // dfs_synth_ctrl
